// ---- pkg/dbl_pkg.sv ----
package dbl_pkg;

    // ************************************************************
    // Bus modes and pin timing.
    // ************************************************************
    typedef enum logic [1:0]
    {
        MODE_WIDE      = 2'b00,
        MODE_BYTE_SYNC = 2'b01,
        MODE_BYTE_SEP  = 2'b10
    } dbl_mode_e;

    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned SETUP_NS        = 60;
    localparam int unsigned STROBE_NS       = 70;
    localparam int unsigned HOLD_NS         = 20;
    localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] CODE_NEG_FULL   = 16'h0000;
    localparam logic [15:0] CODE_POS_FULL   = 16'hFFFF;

    // ************************************************************
    // Pin group driven toward the converter.
    // ************************************************************
    typedef struct packed
    {
        logic        chip_select_n;
        logic        upper_byte_latch_enable_n;
        logic        lower_byte_latch_enable_n;
        logic        output_register_load_n;
        logic [15:0] data;
    } dbl_pins_s;

endpackage

// ---- core/dbl_strobe_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Counts one phase of a write cycle; done pulses when the count expires.
module dbl_strobe_timer
#(
    parameter int unsigned WIDTH = 4
)
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] count,
    output logic                  done
);

    logic [WIDTH-1:0] cnt_q;
    logic             run_q;

    // A one-bit counter cannot tell a running count from its last cycle.
    if (WIDTH < 2)
    begin : g_width_check
        $error("strobe timer needs at least two count bits");
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= count;
            run_q <= 1'b1;
        end
        else if (run_q)
        begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q <= 1)
            begin
                run_q <= 1'b0;
            end
        end
    end

    assign done = run_q && (cnt_q <= 1);

endmodule

`default_nettype wire

// ---- core/dbl_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - The output register loads in its own cycle or together with one or both byte latches.
// - A wide host may hold load low and strobe both byte enables together under chip select; this host pulses load low with the enables instead.
// - A byte-wide host writes two bytes and loads the output register as the second enters.
// - A byte-wide host writes the two bytes in separate cycles, one enable per cycle.
// - The host raises an enable before changing data while all latches are transparent.
module dbl_host
(
    input  wire logic              SYS_CLK,
    input  wire logic              RST_B,
    input  wire logic              START,
    input  wire logic [15:0]       WORD,
    input  wire dbl_pkg::dbl_mode_e MODE,
    output logic                   BUSY,
    output logic                   DONE,
    output logic                   INITIALISED,
    output dbl_pkg::dbl_pins_s     PINS
);

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD   = 3'b011,
        ST_NEXT   = 3'b100
    } dbl_state_e;

    // ************************************************************
    // Write sequencing.
    // ************************************************************
    dbl_state_e         state_q;
    logic [1:0]         phase_q;
    logic [15:0]        word_q;
    dbl_pkg::dbl_mode_e mode_q;
    dbl_pkg::dbl_pins_s pins_q;
    logic               done_q;
    logic               init_q;
    logic               tmr_start;
    logic [3:0]         tmr_count;
    logic               tmr_done;

    // Index of the last write cycle in each mode.
    function automatic logic [1:0] last_phase(input dbl_pkg::dbl_mode_e m);
        case (m)
            dbl_pkg::MODE_WIDE:      last_phase = 2'd0;
            dbl_pkg::MODE_BYTE_SYNC: last_phase = 2'd1;
            default:                 last_phase = 2'd2;
        endcase
    endfunction

    dbl_strobe_timer #(.WIDTH(4)) u_timer
    (
        .clk   (SYS_CLK),
        .rst_b (RST_B),
        .start (tmr_start),
        .count (tmr_count),
        .done  (tmr_done)
    );

    always_comb
    begin
        tmr_start = 1'b0;
        tmr_count = 4'(dbl_pkg::SETUP_CYC);
        if (state_q == ST_IDLE && START)
        begin
            tmr_start = 1'b1;
        end
        else if (state_q == ST_NEXT)
        begin
            tmr_start = 1'b1;
        end
        else if (tmr_done && state_q == ST_SETUP)
        begin
            tmr_start = 1'b1;
            tmr_count = 4'(dbl_pkg::STROBE_CYC);
        end
        else if (tmr_done && state_q == ST_STROBE)
        begin
            tmr_start = 1'b1;
            tmr_count = 4'(dbl_pkg::HOLD_CYC);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_q <= ST_IDLE;
            phase_q <= 2'd0;
            word_q  <= '0;
            mode_q  <= dbl_pkg::MODE_WIDE;
            done_q  <= 1'b0;
            init_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (START)
                    begin
                        word_q  <= WORD;
                        mode_q  <= MODE;
                        phase_q <= 2'd0;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (tmr_done)
                    begin
                        state_q <= ST_STROBE;
                    end
                end
                ST_STROBE:
                begin
                    if (tmr_done)
                    begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (tmr_done)
                    begin
                        if (phase_q == last_phase(mode_q))
                        begin
                            done_q  <= 1'b1;
                            init_q  <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            state_q <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT:
                begin
                    phase_q <= phase_q + 2'd1;
                    state_q <= ST_SETUP;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin drive.
    // ************************************************************
    // Data and chip select stand through setup, strobe and hold; only the
    // enables pulse, so data never changes while a latch is open.
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pins_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
        end
        else
        begin
            pins_q.upper_byte_latch_enable_n <= 1'b1;
            pins_q.lower_byte_latch_enable_n <= 1'b1;
            pins_q.output_register_load_n    <= 1'b1;
            pins_q.chip_select_n             <= (state_q == ST_IDLE || state_q == ST_NEXT);
            if (mode_q == dbl_pkg::MODE_WIDE)
            begin
                pins_q.data <= word_q;
            end
            else
            begin
                pins_q.data <= (phase_q == 2'd0) ? {word_q[15:8], word_q[15:8]}
                                                 : {word_q[7:0], word_q[7:0]};
            end
            // The strobe covers the whole timed phase, its last cycle included, so the
            // enables stay low for the full strobe count and never fall short of it.
            if (state_q == ST_STROBE)
            begin
                case (mode_q)
                    dbl_pkg::MODE_WIDE:
                    begin
                        // Load pulsed low with both enables makes the output register transparent for the strobe only.
                        pins_q.upper_byte_latch_enable_n <= 1'b0;
                        pins_q.lower_byte_latch_enable_n <= 1'b0;
                        pins_q.output_register_load_n    <= 1'b0;
                    end
                    dbl_pkg::MODE_BYTE_SYNC:
                    begin
                        if (phase_q == 2'd0)
                        begin
                            pins_q.upper_byte_latch_enable_n <= 1'b0;
                        end
                        else
                        begin
                            // Load tied to the second byte enable.
                            pins_q.lower_byte_latch_enable_n <= 1'b0;
                            pins_q.output_register_load_n    <= 1'b0;
                        end
                    end
                    default:
                    begin
                        if (phase_q == 2'd0)
                        begin
                            pins_q.upper_byte_latch_enable_n <= 1'b0;
                        end
                        else if (phase_q == 2'd1)
                        begin
                            pins_q.lower_byte_latch_enable_n <= 1'b0;
                        end
                        else
                        begin
                            pins_q.output_register_load_n <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // The converter's latches follow these levels directly, so every pin is registered.
    assign PINS        = pins_q;
    assign BUSY        = (state_q != ST_IDLE);
    assign DONE        = done_q;
    assign INITIALISED = init_q;

endmodule

`default_nettype wire

// ---- bench/dbl_host_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module dbl_host_asserts
(
    input wire logic               SYS_CLK,
    input wire logic               RST_B,
    input wire logic               START,
    input wire logic [15:0]        WORD,
    input wire dbl_pkg::dbl_mode_e MODE,
    input wire logic               BUSY,
    input wire logic               DONE,
    input wire logic               INITIALISED,
    input wire dbl_pkg::dbl_pins_s PINS
);
    wire logic cs_n = PINS.chip_select_n;
    wire logic hi_n = PINS.upper_byte_latch_enable_n;
    wire logic lo_n = PINS.lower_byte_latch_enable_n;
    wire logic ld_n = PINS.output_register_load_n;
    wire logic open = !(hi_n && lo_n && ld_n);

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    // ************************************************************
    // Write cycle phases.
    // ************************************************************
    sequence strobe_s;
        (!hi_n)[*7];
    endsequence
    sequence hold_s;
        !cs_n && $stable(PINS.data);
    endsequence

    idle_cs_high_a: assert property (!BUSY && $past(!BUSY) |-> cs_n)
        else $error("chip select low while idle");
    enable_needs_cs_a: assert property (open |-> !cs_n)
        else $error("latch enable without chip select");
    load_pairing_a: assert property (!hi_n && !lo_n |-> !ld_n)
        else $error("both byte enables without load");
    strobe_width_a: assert property ($fell(hi_n) |-> strobe_s)
        else $error("upper strobe too short");
    data_steady_a: assert property (open && $past(open) |-> $stable(PINS.data))
        else $error("data moved under open latch");
    hold_after_a: assert property ($rose(hi_n) |-> hold_s)
        else $error("no hold after upper strobe");
    start_reach_a: assert property (START && !BUSY |-> ##[1:4] !cs_n)
        else $error("start did not select device");
    done_init_a: assert property (DONE |=> INITIALISED && !DONE)
        else $error("done not single or not initialised");
endmodule

bind dbl_host dbl_host_asserts i_dbl_host_asserts
(
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .START(START), .WORD(WORD), .MODE(MODE),
    .BUSY(BUSY), .DONE(DONE), .INITIALISED(INITIALISED), .PINS(PINS)
);
`default_nettype wire

// ---- bench/dbl_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module dbl_dev_model
(
    input wire dbl_pkg::dbl_pins_s pins,
    output logic [15:0]            dac_code
);
    logic [7:0] hi_q;
    logic [7:0] lo_q;

    // Ranks start unknown and have no reset, like the real part.
    // Each latch holds whenever its enable is high.
    always @*
    begin
        if (!pins.chip_select_n && !pins.upper_byte_latch_enable_n)
            hi_q = pins.data[15:8];
        if (!pins.chip_select_n && !pins.lower_byte_latch_enable_n)
            lo_q = pins.data[7:0];
        if (!pins.chip_select_n && !pins.output_register_load_n)
            dac_code = {hi_q, lo_q};
    end
endmodule
`default_nettype wire

// ---- bench/dbl_host_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

module dbl_host_tb;
    logic               SYS_CLK;
    logic               RST_B;
    logic               START;
    logic [15:0]        WORD;
    dbl_pkg::dbl_mode_e MODE;
    logic               BUSY;
    logic               DONE;
    logic               INITIALISED;
    dbl_pkg::dbl_pins_s PINS;
    logic [15:0]        dac_code;
    int                 num_errors;
    int                 checks_done;

    dbl_host i_dbl_host (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .START(START), .WORD(WORD), .MODE(MODE),
        .BUSY(BUSY), .DONE(DONE), .INITIALISED(INITIALISED), .PINS(PINS));
    dbl_dev_model i_dbl_dev_model (.pins(PINS), .dac_code(dac_code));

    initial
    begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    task automatic conclude();
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************************************
    // Bounded waits and transfers.
    // ************************************************************
    task automatic wait_for(input int sel);
        int n;
        n = 0;
        while ((sel == 0) ? (DONE !== 1'b1) : (PINS.upper_byte_latch_enable_n !== 1'b0))
        begin
            @(posedge SYS_CLK);
            #1;
            n++;
            if (n > 300)
            begin
                num_errors++;
                conclude();
            end
        end
    endtask

    task automatic write_word(input logic [15:0] w, input dbl_pkg::dbl_mode_e m);
        logic [15:0] old;
        old = dac_code;
        @(posedge SYS_CLK);
        START <= 1'b1;
        WORD  <= w;
        MODE  <= m;
        @(posedge SYS_CLK);
        START <= 1'b0;
        #1;
        if (m != dbl_pkg::MODE_WIDE)
        begin
            wait_for(1);
            `CHK("dac_early", old, dac_code)
        end
        wait_for(0);
        `CHK("dac", w, dac_code)
        `CHK("init", 1'b1, INITIALISED)
    endtask

    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic test_reset_levels();
        `CHK("pins", 20'hF0000, PINS)
        `CHK("busy", 1'b0, BUSY)
        `CHK("init", 1'b0, INITIALISED)
    endtask

    task automatic test_modes();
        logic [15:0] words [3] = '{dbl_pkg::CODE_POS_FULL, dbl_pkg::CODE_NEG_FULL, 16'hA55A};
        for (int m = 0; m < 3; m++)
            foreach (words[i])
                write_word(words[i] ^ 16'(m), dbl_pkg::dbl_mode_e'(m));
    endtask

    task automatic test_refuse();
        @(posedge SYS_CLK);
        START <= 1'b1;
        WORD  <= 16'h1111;
        MODE  <= dbl_pkg::MODE_WIDE;
        repeat (3) @(posedge SYS_CLK);
        WORD  <= 16'h2222;
        @(posedge SYS_CLK);
        START <= 1'b0;
        #1;
        wait_for(0);
        `CHK("dac_refuse", 16'h1111, dac_code)
        repeat (20) @(posedge SYS_CLK);
        #1;
        `CHK("busy_after", 1'b0, BUSY)
    endtask

    task automatic test_mid_reset();
        @(posedge SYS_CLK);
        START <= 1'b1;
        WORD  <= 16'h5A5A;
        MODE  <= dbl_pkg::MODE_BYTE_SEP;
        @(posedge SYS_CLK);
        START <= 1'b0;
        repeat (4) @(posedge SYS_CLK);
        RST_B <= 1'b0;
        #1;
        test_reset_levels();
        repeat (2) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        write_word(16'h8001, dbl_pkg::MODE_BYTE_SYNC);
    endtask

    initial
    begin
        num_errors  = 0;
        checks_done = 0;
        RST_B       = 1'b0;
        START       = 1'b0;
        WORD        = 16'h0000;
        MODE        = dbl_pkg::MODE_WIDE;
        repeat (12) @(posedge SYS_CLK);
        test_reset_levels();
        RST_B <= 1'b1;
        test_modes();
        test_refuse();
        test_mid_reset();
        conclude();
    end
endmodule
`default_nettype wire
